//--- src/cam_pkg.sv
`default_nettype none
// ============================================================
// Shared constants of the counter array mode register
package cam_pkg;
  localparam logic [7:0] CAM_MODE_ADDR  = 8'hd9;  // Register address
  localparam logic [7:0] CAM_MODE_RESET = 8'h40;  // Watchdog enabled after reset
  localparam int         CAM_IDLE_BIT   = 7;
  localparam int         CAM_WDOG_BIT   = 6;
  localparam int         CAM_LOCK_BIT   = 5;
  localparam int         CAM_ZERO_BIT   = 4;
  localparam int         CAM_SEL_LSB    = 1;
  localparam int         CAM_IRQE_BIT   = 0;
  localparam logic [3:0] CAM_DIV12_LAST = 4'hb;   // Prescaler wraps after 12 clocks
  localparam logic [1:0] CAM_DIV4_LAST  = 2'h3;   // Every fourth prescaler clock
  localparam logic [2:0] CAM_DIV8_LAST  = 3'h7;   // Slow clock divider wraps after 8 edges
  // Timebase select codes
  localparam logic [2:0] CAM_SEL_DIV12  = 3'h0;
  localparam logic [2:0] CAM_SEL_DIV4   = 3'h1;
  localparam logic [2:0] CAM_SEL_T0OVF  = 3'h2;
  localparam logic [2:0] CAM_SEL_CNTIN  = 3'h3;
  localparam logic [2:0] CAM_SEL_SYSCLK = 3'h4;
  localparam logic [2:0] CAM_SEL_EXTCLK = 3'h5;
  localparam logic [2:0] CAM_SEL_RTCCLK = 3'h6;
  localparam logic [2:0] CAM_SEL_RSVD   = 3'h7;
endpackage
`default_nettype wire

//--- src/cam_mode_ctrl.sv
`default_nettype none
module cam_mode_ctrl
  import cam_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata_ff,
  // Event sources
  input  wire logic       cpu_idle,
  input  wire logic       timer0_ovf,
  input  wire logic       external_count_input,
  input  wire logic       ext_osc_clk,
  input  wire logic       rtc_clk,
  input  wire logic       counter_overflow_flag,
  // Results
  output logic            count_tick_ff,
  output logic            watchdog_enable_ff,
  output logic            overflow_irq_ff
);

  // ============================================================
  // Mode register
  logic       idle_suspend_ff;
  logic       watchdog_lock_ff;
  logic [2:0] timebase_select_ff;
  logic       overflow_irq_enable_ff;
  logic       mode_wr;
  logic       nxt_lock;

  // Address decode shared by the write and read paths
  function automatic logic hits_mode(input logic [7:0] addr);
    return addr == CAM_MODE_ADDR;
  endfunction

  assign mode_wr  = sfr_wr && hits_mode(sfr_addr);
  assign nxt_lock = watchdog_lock_ff | sfr_wdata[CAM_LOCK_BIT];

  // Lock only sets by write; only reset clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      watchdog_lock_ff <= CAM_MODE_RESET[CAM_LOCK_BIT];
    end else if (mode_wr) begin
      watchdog_lock_ff <= nxt_lock;
    end
  end

  // Watchdog enable: setting lock also enables, clearing needs lock clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      watchdog_enable_ff <= CAM_MODE_RESET[CAM_WDOG_BIT];
    end else if (mode_wr) begin
      watchdog_enable_ff <= nxt_lock | sfr_wdata[CAM_WDOG_BIT];
    end
  end

  // Timebase and idle settings frozen while watchdog runs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idle_suspend_ff    <= CAM_MODE_RESET[CAM_IDLE_BIT];
      timebase_select_ff <= CAM_MODE_RESET[CAM_SEL_LSB +: 3];
    end else if (mode_wr && !watchdog_enable_ff) begin
      idle_suspend_ff    <= sfr_wdata[CAM_IDLE_BIT];
      timebase_select_ff <= sfr_wdata[CAM_SEL_LSB +: 3];
    end
  end

  // Interrupt enable is always writable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      overflow_irq_enable_ff <= CAM_MODE_RESET[CAM_IRQE_BIT];
    end else if (mode_wr) begin
      overflow_irq_enable_ff <= sfr_wdata[CAM_IRQE_BIT];
    end
  end

  // Read data; unused bit forced low, other addresses read zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sfr_rdata_ff <= 8'h00;
    end else if (sfr_rd && hits_mode(sfr_addr)) begin
      sfr_rdata_ff <= {idle_suspend_ff, watchdog_enable_ff, watchdog_lock_ff, 1'b0,
                       timebase_select_ff, overflow_irq_enable_ff};
    end else begin
      sfr_rdata_ff <= 8'h00;
    end
  end

  // Masked overflow request
  always_ff @(posedge clk) begin
    if (!nrst) begin
      overflow_irq_ff <= 1'b0;
    end else begin
      overflow_irq_ff <= counter_overflow_flag & overflow_irq_enable_ff;
    end
  end

  // ============================================================
  // Timebase sources
  logic [3:0] presc_ff;
  logic       cnt_in_prev_ff;
  logic [1:0] ext_sync_ff;
  logic [1:0] rtc_sync_ff;
  logic       ext_prev_ff;
  logic       rtc_prev_ff;
  logic [2:0] ext_div_ff;
  logic [2:0] rtc_div_ff;
  logic       ext_tick;
  logic       rtc_tick;

  assign ext_tick = ext_sync_ff[1] && !ext_prev_ff && (ext_div_ff == CAM_DIV8_LAST);
  assign rtc_tick = rtc_sync_ff[1] && !rtc_prev_ff && (rtc_div_ff == CAM_DIV8_LAST);

  // System clock prescaler, modulo 12
  always_ff @(posedge clk) begin
    if (!nrst) begin
      presc_ff <= 4'h0;
    end else if (presc_ff == CAM_DIV12_LAST) begin
      presc_ff <= 4'h0;
    end else begin
      presc_ff <= presc_ff + 4'h1;
    end
  end

  // Count input history for falling edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_in_prev_ff <= 1'b0;
    end else begin
      cnt_in_prev_ff <= external_count_input;
    end
  end

  // Two-stage synchronisers and rising edge history for slow clocks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_sync_ff <= 2'h0;
      rtc_sync_ff <= 2'h0;
      ext_prev_ff <= 1'b0;
      rtc_prev_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[0], ext_osc_clk};
      rtc_sync_ff <= {rtc_sync_ff[0], rtc_clk};
      ext_prev_ff <= ext_sync_ff[1];
      rtc_prev_ff <= rtc_sync_ff[1];
    end
  end

  // Divide-by-8 counters on synchronised rising edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_div_ff <= 3'h0;
      rtc_div_ff <= 3'h0;
    end else begin
      if (ext_sync_ff[1] && !ext_prev_ff) begin
        ext_div_ff <= ext_div_ff + 3'h1;
      end
      if (rtc_sync_ff[1] && !rtc_prev_ff) begin
        rtc_div_ff <= rtc_div_ff + 3'h1;
      end
    end
  end

  // ============================================================
  // Tick selection and idle gating
  logic nxt_tick;
  logic suspend;

  assign suspend = idle_suspend_ff & cpu_idle;

  always_comb begin
    nxt_tick = 1'b0;
    unique case (timebase_select_ff)
      CAM_SEL_DIV12:  nxt_tick = (presc_ff == CAM_DIV12_LAST);
      CAM_SEL_DIV4:   nxt_tick = (presc_ff[1:0] == CAM_DIV4_LAST);
      CAM_SEL_T0OVF:  nxt_tick = timer0_ovf;
      CAM_SEL_CNTIN:  nxt_tick = cnt_in_prev_ff & ~external_count_input;
      CAM_SEL_SYSCLK: nxt_tick = 1'b1;
      CAM_SEL_EXTCLK: nxt_tick = ext_tick;
      CAM_SEL_RTCCLK: nxt_tick = rtc_tick;
      CAM_SEL_RSVD:   nxt_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_tick_ff <= 1'b0;
    end else begin
      count_tick_ff <= nxt_tick & ~suspend;
    end
  end

  // ============================================================
  // Assertions
  property p_idle_halt;
    @(posedge clk) disable iff (!nrst) (idle_suspend_ff && cpu_idle) |=> !count_tick_ff;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("tick during idle suspend");

  property p_lock_implies_wdt;
    @(posedge clk) disable iff (!nrst) watchdog_lock_ff |-> watchdog_enable_ff;
  endproperty
  a_lock_implies_wdt: assert property (p_lock_implies_wdt) else $error("locked but disabled");

  property p_lock_hold;
    @(posedge clk) disable iff (!nrst) (watchdog_lock_ff && mode_wr) |=> watchdog_enable_ff && watchdog_lock_ff;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked watchdog disabled");

  property p_div12;
    @(posedge clk) disable iff (!nrst)
      (timebase_select_ff == CAM_SEL_DIV12 && !suspend) |-> ##1 (count_tick_ff == $past(presc_ff == CAM_DIV12_LAST));
  endproperty
  a_div12: assert property (p_div12) else $error("div12 tick wrong");

  property p_t0;
    @(posedge clk) disable iff (!nrst)
      (timebase_select_ff == CAM_SEL_T0OVF && timer0_ovf && !suspend) |=> count_tick_ff;
  endproperty
  a_t0: assert property (p_t0) else $error("timer0 overflow tick missed");

  property p_cnt_fall;
    @(posedge clk) disable iff (!nrst)
      (timebase_select_ff == CAM_SEL_CNTIN && !suspend && $fell(external_count_input)) |=> count_tick_ff;
  endproperty
  a_cnt_fall: assert property (p_cnt_fall) else $error("count input edge missed");

  property p_rsvd;
    @(posedge clk) disable iff (!nrst) (timebase_select_ff == CAM_SEL_RSVD) |=> !count_tick_ff;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code ticked");

  property p_irq;
    @(posedge clk) disable iff (!nrst) overflow_irq_ff == $past(counter_overflow_flag && overflow_irq_enable_ff);
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request wrong");

  property p_reset_wdt;
    @(posedge clk) $rose(nrst) |-> watchdog_enable_ff && !watchdog_lock_ff;
  endproperty
  a_reset_wdt: assert property (p_reset_wdt) else $error("watchdog off after reset");

  property p_frozen;
    @(posedge clk) disable iff (!nrst)
      (mode_wr && watchdog_enable_ff) |=> $stable(timebase_select_ff) && $stable(idle_suspend_ff);
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen field changed");

  property p_disable;
    @(posedge clk) disable iff (!nrst)
      (mode_wr && !watchdog_lock_ff && !sfr_wdata[CAM_WDOG_BIT] && !sfr_wdata[CAM_LOCK_BIT]) |=> !watchdog_enable_ff;
  endproperty
  a_disable: assert property (p_disable) else $error("watchdog not disabled");

  property p_bit4;
    @(posedge clk) disable iff (!nrst) !sfr_rdata_ff[CAM_ZERO_BIT];
  endproperty
  a_bit4: assert property (p_bit4) else $error("unused bit read high");

  c_lock:    cover property (@(posedge clk) disable iff (!nrst) $rose(watchdog_lock_ff));
  c_wdt_off: cover property (@(posedge clk) disable iff (!nrst) $fell(watchdog_enable_ff));
  c_ext:     cover property (@(posedge clk) disable iff (!nrst) ext_tick && timebase_select_ff == CAM_SEL_EXTCLK);
  c_irq:     cover property (@(posedge clk) disable iff (!nrst) $rose(overflow_irq_ff));

endmodule
`default_nettype wire

//--- sim/test_counter_array_mode_control.sv
`default_nettype none
module test_counter_array_mode_control
  import cam_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Design signals and bench counters
  logic       clk, nrst, sfr_wr, sfr_rd, cpu_idle, timer0_ovf;
  logic       external_count_input, ext_osc_clk, rtc_clk, counter_overflow_flag;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_ff;
  logic       count_tick_ff, watchdog_enable_ff, overflow_irq_ff;
  int         num_errors, checks, ticks;
  int         exp_ticks [8] = '{8, 24, 5, 6, 96, 2, 2, 0};

  cam_mode_ctrl dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff), .cpu_idle(cpu_idle),
    .timer0_ovf(timer0_ovf), .external_count_input(external_count_input),
    .ext_osc_clk(ext_osc_clk), .rtc_clk(rtc_clk), .counter_overflow_flag(counter_overflow_flag),
    .count_tick_ff(count_tick_ff), .watchdog_enable_ff(watchdog_enable_ff),
    .overflow_irq_ff(overflow_irq_ff));

  // ==========================================
  // Clock, tick counter and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (count_tick_ff === 1'b1) ticks <= ticks + 1;
  end
  initial begin
    #3000000;
    num_errors++;
    stop_test();
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
  endtask
  // Register write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask
  // Register read, data registered at the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    chk("mode register", sfr_rdata_ff, exp);
  endtask
  // Select a timebase, drive its source for 96 cycles, count ticks
  task automatic run(input logic [2:0] sel, input logic idl, input logic idle_in, input int exp);
    int base;
    wr(CAM_MODE_ADDR, {idl, 3'h0, sel, 1'b0});
    cpu_idle = idle_in;
    repeat (2) @(posedge clk);
    #1 base = ticks;
    for (int c = 0; c < 96; c++) begin
      timer0_ovf = (sel == 3'h2) && (c < 15) && (c % 3 == 0);
      external_count_input = !((sel == 3'h3) && (c < 48) && (c % 8 >= 4));
      ext_osc_clk = (sel == 3'h5) && (c < 64) && (c % 4 >= 2);
      rtc_clk = (sel == 3'h6) && (c < 64) && (c % 4 >= 2);
      @(posedge clk);
      #1;
    end
    chk("tick count", 8'(ticks - base), 8'(exp));
    cpu_idle = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {sfr_wr, sfr_rd, cpu_idle, timer0_ovf, ext_osc_clk, rtc_clk, counter_overflow_flag} = '0;
    {sfr_addr, sfr_wdata} = '0;
    nrst = 1'b0;
    external_count_input = 1'b1;
    num_errors = 0;
    checks = 0;
    do_reset();
    rd(CAM_MODE_ADDR, 8'h40);
    chk("watchdog enable", {7'h00, watchdog_enable_ff}, 8'h01);
    wr(8'hd8, 8'h00);
    rd(CAM_MODE_ADDR, 8'h40);
    rd(8'hd8, 8'h00);
    wr(CAM_MODE_ADDR, 8'h8e);
    rd(CAM_MODE_ADDR, 8'h00);
    chk("watchdog enable", {7'h00, watchdog_enable_ff}, 8'h00);
    wr(CAM_MODE_ADDR, 8'h1a);
    rd(CAM_MODE_ADDR, 8'h0a);
    $display("test register access done");
    for (int s = 0; s < 8; s++) run(3'(s), 1'b0, 1'b0, exp_ticks[s]);
    run(3'h4, 1'b1, 1'b1, 0);
    run(3'h4, 1'b0, 1'b1, 96);
    $display("test timebase done");
    wr(CAM_MODE_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("overflow irq", {7'h00, overflow_irq_ff}, 8'h00);
    counter_overflow_flag = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("overflow irq", {7'h00, overflow_irq_ff}, 8'h01);
    wr(CAM_MODE_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("overflow irq", {7'h00, overflow_irq_ff}, 8'h00);
    counter_overflow_flag = 1'b0;
    $display("test interrupt done");
    wr(CAM_MODE_ADDR, 8'h40);
    wr(CAM_MODE_ADDR, 8'hff);
    rd(CAM_MODE_ADDR, 8'h61);
    wr(CAM_MODE_ADDR, 8'h00);
    rd(CAM_MODE_ADDR, 8'h60);
    chk("watchdog enable", {7'h00, watchdog_enable_ff}, 8'h01);
    do_reset();
    rd(CAM_MODE_ADDR, 8'h40);
    wr(CAM_MODE_ADDR, 8'h00);
    rd(CAM_MODE_ADDR, 8'h00);
    $display("test lock done");
    stop_test();
  end
endmodule
`default_nettype wire
